//--- rtl/codec_agc_status_output_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none

module codec_agc_status_output_ctrl_regs
	import codec_regs_pkg::*;
#(
	parameter int unsigned DEBOUNCE_UNIT_CYCLES = DEBOUNCE_UNIT_CYC,
	parameter int unsigned GAIN_W               = 8
)
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	// ahb-lite slave
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	output logic [31:0]            hrdata_o,
	// converter and gain-loop state
	input  wire logic [GAIN_W-1:0] pga_applied_left_i,
	input  wire logic [GAIN_W-1:0] pga_programmed_left_i,
	input  wire logic [GAIN_W-1:0] pga_applied_right_i,
	input  wire logic [GAIN_W-1:0] pga_programmed_right_i,
	input  wire logic              adc_powered_left_i,
	input  wire logic              adc_powered_right_i,
	input  wire logic              below_noise_left_i,
	input  wire logic              below_noise_right_i,
	input  wire logic [GAIN_W-1:0] agc_gain_left_i,
	input  wire logic [GAIN_W-1:0] agc_max_left_i,
	input  wire logic [GAIN_W-1:0] agc_gain_right_i,
	input  wire logic [GAIN_W-1:0] agc_max_right_i,
	input  wire logic              double_rate_audio_i,
	// output stage events
	input  wire logic              short_detected_i,
	input  wire logic              sample_tick_i,
	// output stage controls
	output logic                   dac_power_left_o,
	output logic                   dac_power_right_o,
	output logic                   headphone_common_output_differential_o,
	output logic                   headphone_common_output_constant_vcm_o,
	output logic                   headphone_common_output_single_ended_o,
	output logic                   short_protect_en_o,
	output logic                   short_current_limit_o,
	output logic                   driver_power_down_o,
	output logic [1:0]             common_mode_sel_o,
	output logic                   left_line2_positive_o,
	output logic                   left_line2_negative_o,
	output logic                   right_line2_positive_o,
	output logic                   right_line2_negative_o,
	output logic                   volume_step_o,
	output logic [4:0]             right_noise_debounce_o,
	output logic [2:0]             right_signal_debounce_o,
	output logic                   right_signal_below_o,
	// interrupt
	output logic                   irq_o
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]       debounce;
		logic [7:0]       dac_power;
		logic [7:0]       hp_short;
		logic [7:0]       bypass;
		logic [7:0]       flags;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic             wr_pend;
		logic [7:0]       wr_idx;
		logic [31:0]      rdata;
		logic             irq;
		logic             hp_off;
		logic             cur_lim;
		logic             step_half;
		logic             vol_step;
		logic [2:0]       headphone_common_output;
		logic [3:0]       line2;
	} state_t;

	state_t q;
	state_t d;

	debounce_if dbus ();

	// ****************************************
	// right channel debounce
	// ****************************************
	assign dbus.noise_code  = q.debounce[NOISE_DB_LSB +: 5];
	assign dbus.signal_code = q.debounce[SIGNAL_DB_LSB +: 3];
	assign dbus.double_rate = double_rate_audio_i;
	assign dbus.raw_below   = below_noise_right_i;

	gain_loop_debounce #(
		.UNIT_CYCLES (DEBOUNCE_UNIT_CYCLES)
	) u_right_debounce (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.db        (dbus.timer)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] merge
	(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic [7:0] wmask
	);
		return (old_val & ~wmask) | (new_val & wmask);
	endfunction : merge

	function automatic logic [1:0] route(input logic [1:0] code);
		// bit 1 negative leg, bit 0 positive leg, both for differential
		return {code[1], code[0]};
	endfunction : route

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic             take;
		logic [7:0]       idx;
		logic [7:0]       rd;
		logic [IRQ_W-1:0] events;
		logic             short_on;
		d        = q;
		take     = hsel_i & hready_i & htrans_i[1];
		idx      = haddr_i[ADDR_LSB +: 8];
		rd       = REG_RESET;
		events   = '0;
		short_on = q.hp_short[SHORT_EN_BIT];

		// ****************************************
		// live flags, one cycle of history except the debounced right signal flag
		// ****************************************
		d.flags[FLAG_PGA_LEFT]  =
			(pga_applied_left_i == pga_programmed_left_i);
		d.flags[FLAG_PGA_RIGHT] =
			(pga_applied_right_i == pga_programmed_right_i);
		d.flags[FLAG_PWR_LEFT]  = adc_powered_left_i;
		d.flags[FLAG_PWR_RIGHT] = adc_powered_right_i;
		d.flags[FLAG_SIG_LEFT]  = below_noise_left_i;
		d.flags[FLAG_SIG_RIGHT] = dbus.below;
		d.flags[FLAG_SAT_LEFT]  =
			(agc_gain_left_i == agc_max_left_i);
		d.flags[FLAG_SAT_RIGHT] =
			(agc_gain_right_i == agc_max_right_i);

		// ****************************************
		// data phase of a write
		// ****************************************
		d.wr_pend = 1'b0;
		if (q.wr_pend)
		begin
			case (q.wr_idx)
				IDX_RIGHT_DEBOUNCE:
					d.debounce = merge(q.debounce, hwdata_i[7:0],
						DEBOUNCE_WMASK);
				IDX_DAC_POWER_HP:
					d.dac_power = merge(q.dac_power, hwdata_i[7:0],
						DAC_POWER_WMASK);
				IDX_HP_SHORT:
					d.hp_short = merge(q.hp_short, hwdata_i[7:0],
						HP_SHORT_WMASK);
				IDX_OUT_BYPASS:
					d.bypass = merge(q.bypass, hwdata_i[7:0],
						BYPASS_WMASK);
				IDX_IRQ_MASK:
					d.irq_mask = hwdata_i[IRQ_W-1:0];
				// flags and reserved slot ignore writes
				default:
					d.wr_pend = 1'b0;
			endcase
		end

		// ****************************************
		// address phase, read data formed from the post-write values
		// ****************************************
		if (take)
		begin
			d.wr_pend = hwrite_i;
			d.wr_idx  = idx;
		end
		case (idx)
			IDX_RIGHT_DEBOUNCE: rd = d.debounce;
			IDX_ADC_FLAGS:      rd = q.flags;
			IDX_DAC_POWER_HP:   rd = d.dac_power;
			IDX_HP_SHORT:       rd = d.hp_short;
			IDX_RESERVED:       rd = REG_RESET;
			IDX_OUT_BYPASS:     rd = d.bypass;
			IDX_IRQ_STATUS:     rd = 8'(q.irq_status);
			IDX_IRQ_MASK:       rd = 8'(d.irq_mask);
			default:            rd = REG_RESET;
		endcase
		if (take && !hwrite_i)
			d.rdata = {24'h000000, rd};

		// ****************************************
		// interrupt events, a read clears, a new event wins
		// ****************************************
		events[IRQ_SIG_RIGHT] = d.flags[FLAG_SIG_RIGHT]
			^ q.flags[FLAG_SIG_RIGHT];
		events[IRQ_SAT_LEFT]  = d.flags[FLAG_SAT_LEFT]
			& ~q.flags[FLAG_SAT_LEFT];
		events[IRQ_SAT_RIGHT] = d.flags[FLAG_SAT_RIGHT]
			& ~q.flags[FLAG_SAT_RIGHT];
		events[IRQ_SHORT]     = short_detected_i & short_on;
		if (take && !hwrite_i && idx == IDX_IRQ_STATUS)
			d.irq_status = events;
		else
			d.irq_status = q.irq_status | events;
		d.irq = |(d.irq_status & d.irq_mask);

		// ****************************************
		// short protection behaviour
		// ****************************************
		if (!d.hp_short[SHORT_EN_BIT] || !d.hp_short[SHORT_MODE_BIT])
			d.hp_off = 1'b0;
		else if (short_detected_i)
			d.hp_off = 1'b1;
		// registered so the limit pin comes straight from a flop
		d.cur_lim = d.hp_short[SHORT_EN_BIT]
			& ~d.hp_short[SHORT_MODE_BIT];

		// ****************************************
		// headphone common output, reserved code drives nothing
		// ****************************************
		case (d.dac_power[HP_COMMON_LSB +: 2])
			HP_COMMON_DIFF: d.headphone_common_output = 3'h1;
			HP_COMMON_VCM:  d.headphone_common_output = 3'h2;
			HP_COMMON_SE:   d.headphone_common_output = 3'h4;
			default:        d.headphone_common_output = 3'h0;
		endcase

		d.line2 = {route(d.bypass[BYPASS_LEFT_LSB +: 2]),
			route(d.bypass[BYPASS_RIGHT_LSB +: 2])};

		// ****************************************
		// volume soft stepping
		// ****************************************
		d.vol_step = 1'b0;
		if (sample_tick_i)
		begin
			case (d.bypass[SOFT_STEP_LSB +: 2])
				STEP_EVERY_FS:
				begin
					d.vol_step  = 1'b1;
					d.step_half = 1'b0;
				end
				STEP_EVERY_2FS:
				begin
					d.vol_step  = q.step_half;
					d.step_half = ~q.step_half;
				end
				default:
					d.step_half = 1'b0;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			q <= '0;
		else
			q <= d;
	end

	// ****************************************
	// bus outputs
	// ****************************************
	assign hreadyout_o             = 1'b1;
	assign hresp_o                 = 1'b0;
	assign hrdata_o                = q.rdata;

	// ****************************************
	// output stage
	// ****************************************
	assign dac_power_left_o        = q.dac_power[DAC_LEFT_BIT];
	assign dac_power_right_o       = q.dac_power[DAC_RIGHT_BIT];
	assign headphone_common_output_differential_o    = q.headphone_common_output[0];
	assign headphone_common_output_constant_vcm_o    = q.headphone_common_output[1];
	assign headphone_common_output_single_ended_o    = q.headphone_common_output[2];
	assign short_protect_en_o      = q.hp_short[SHORT_EN_BIT];
	assign short_current_limit_o   = q.cur_lim;
	assign driver_power_down_o     = q.hp_off;
	assign common_mode_sel_o       = q.bypass[VCM_LSB +: 2];
	assign left_line2_negative_o   = q.line2[3];
	assign left_line2_positive_o   = q.line2[2];
	assign right_line2_negative_o  = q.line2[1];
	assign right_line2_positive_o  = q.line2[0];
	assign volume_step_o           = q.vol_step;

	// ****************************************
	// debounce and interrupt
	// ****************************************
	assign right_noise_debounce_o  = q.debounce[NOISE_DB_LSB +: 5];
	assign right_signal_debounce_o = q.debounce[SIGNAL_DB_LSB +: 3];
	assign right_signal_below_o    = q.flags[FLAG_SIG_RIGHT];
	assign irq_o                   = q.irq;

endmodule : codec_agc_status_output_ctrl_regs

`default_nettype wire

//--- rtl/codec_regs_pkg.sv
package codec_regs_pkg;

	// ****************************************
	// clock and debounce timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_PS      = 5000;
	localparam int unsigned DEBOUNCE_UNIT_PS   = 500000000;
	localparam int unsigned DEBOUNCE_UNIT_CYC  =
		DEBOUNCE_UNIT_PS / CLK_PERIOD_PS;
	localparam int unsigned DEBOUNCE_CNT_W     = 12;

	// ****************************************
	// register indices, byte address is index times four
	// ****************************************
	localparam logic [7:0] IDX_RIGHT_DEBOUNCE  = 8'h23;
	localparam logic [7:0] IDX_ADC_FLAGS       = 8'h24;
	localparam logic [7:0] IDX_DAC_POWER_HP    = 8'h25;
	localparam logic [7:0] IDX_HP_SHORT        = 8'h26;
	localparam logic [7:0] IDX_RESERVED        = 8'h27;
	localparam logic [7:0] IDX_OUT_BYPASS      = 8'h28;
	localparam logic [7:0] IDX_IRQ_STATUS      = 8'h29;
	localparam logic [7:0] IDX_IRQ_MASK        = 8'h2A;
	localparam int unsigned ADDR_LSB           = 2;

	// ****************************************
	// reset values and writable bits
	// ****************************************
	localparam logic [7:0] REG_RESET           = 8'h00;
	localparam logic [7:0] DEBOUNCE_WMASK      = 8'hFF;
	localparam logic [7:0] DAC_POWER_WMASK     = 8'hF0;
	localparam logic [7:0] HP_SHORT_WMASK      = 8'h06;
	localparam logic [7:0] BYPASS_WMASK        = 8'hFF;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned NOISE_DB_LSB       = 3;
	localparam int unsigned SIGNAL_DB_LSB      = 0;
	localparam int unsigned DAC_LEFT_BIT       = 7;
	localparam int unsigned DAC_RIGHT_BIT      = 6;
	localparam int unsigned HP_COMMON_LSB      = 4;
	localparam int unsigned SHORT_EN_BIT       = 2;
	localparam int unsigned SHORT_MODE_BIT     = 1;
	localparam int unsigned VCM_LSB            = 6;
	localparam int unsigned BYPASS_LEFT_LSB    = 4;
	localparam int unsigned BYPASS_RIGHT_LSB   = 2;
	localparam int unsigned SOFT_STEP_LSB      = 0;

	localparam int unsigned FLAG_PGA_LEFT      = 7;
	localparam int unsigned FLAG_PWR_LEFT      = 6;
	localparam int unsigned FLAG_SIG_LEFT      = 5;
	localparam int unsigned FLAG_SAT_LEFT      = 4;
	localparam int unsigned FLAG_PGA_RIGHT     = 3;
	localparam int unsigned FLAG_PWR_RIGHT     = 2;
	localparam int unsigned FLAG_SIG_RIGHT     = 1;
	localparam int unsigned FLAG_SAT_RIGHT     = 0;

	localparam int unsigned IRQ_W              = 4;
	localparam int unsigned IRQ_SIG_RIGHT      = 0;
	localparam int unsigned IRQ_SAT_LEFT       = 1;
	localparam int unsigned IRQ_SAT_RIGHT      = 2;
	localparam int unsigned IRQ_SHORT          = 3;

	// ****************************************
	// field codes
	// ****************************************
	localparam logic [1:0] HP_COMMON_DIFF      = 2'h0;
	localparam logic [1:0] HP_COMMON_VCM       = 2'h1;
	localparam logic [1:0] HP_COMMON_SE        = 2'h2;
	localparam logic [1:0] STEP_EVERY_FS       = 2'h0;
	localparam logic [1:0] STEP_EVERY_2FS      = 2'h1;
	localparam logic [1:0] AHB_NONSEQ          = 2'h2;
	localparam logic [1:0] AHB_SEQ             = 2'h3;

endpackage : codec_regs_pkg

//--- rtl/debounce_if.sv
`timescale 1ns/1ps
`default_nettype none

interface debounce_if;
	logic [4:0] noise_code;
	logic [2:0] signal_code;
	logic       double_rate;
	logic       raw_below;
	logic       below;

	modport ctrl
	(
		output noise_code,
		output signal_code,
		output double_rate,
		output raw_below,
		input  below
	);

	modport timer
	(
		input  noise_code,
		input  signal_code,
		input  double_rate,
		input  raw_below,
		output below
	);
endinterface : debounce_if

`default_nettype wire

//--- rtl/gain_loop_debounce.sv
`timescale 1ns/1ps
`default_nettype none

module gain_loop_debounce
	import codec_regs_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = DEBOUNCE_UNIT_CYC
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// settings and detector
	debounce_if.timer db
);

	typedef logic [DEBOUNCE_CNT_W-1:0] units_t;

	typedef struct packed {
		logic [31:0] div;
		units_t      cnt;
		logic        below;
	} db_state_t;

	db_state_t q;
	db_state_t d;

	// ****************************************
	// code to time in half-millisecond units
	// ****************************************
	function automatic units_t noise_units(input logic [4:0] code);
		units_t u;
		u = '0;
		if (code == 5'h00)
			u = '0;
		else if (code < 5'h08)
			u = units_t'(1) << code;
		else
			u = units_t'(units_t'(code - 5'h07) * units_t'(128));
		return u;
	endfunction : noise_units

	function automatic units_t signal_units(input logic [2:0] code);
		units_t u;
		u = '0;
		if (code != 3'h0)
			u = units_t'(1) << (code - 3'h1);
		return u;
	endfunction : signal_units

	// ****************************************
	// timer and filter
	// ****************************************
	always_comb
	begin
		logic   tick;
		logic   [31:0] period;
		units_t target;
		d      = q;
		tick   = 1'b0;
		target = '0;
		// double rate shortens the time base, times then leave the table
		period = db.double_rate ? (UNIT_CYCLES >> 1) : UNIT_CYCLES;
		if (q.div >= period - 32'd1)
		begin
			d.div = '0;
			tick  = 1'b1;
		end
		else
			d.div = q.div + 32'd1;
		target = db.raw_below ? noise_units(db.noise_code)
			: signal_units(db.signal_code);
		if (db.raw_below == q.below)
			d.cnt = '0;
		else if (target == '0 || q.cnt >= target)
		begin
			d.below = db.raw_below;
			d.cnt   = '0;
		end
		else if (tick)
			d.cnt = q.cnt + units_t'(1);
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign db.below = q.below;

endmodule : gain_loop_debounce

`default_nettype wire

//--- verif/agc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module agc_regs_monitor
	import codec_regs_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	// bus
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	// events
	input wire logic        short_detected_i,
	input wire logic        sample_tick_i,
	input wire logic        below_noise_right_i,
	// controls
	input wire logic        dac_power_left_o,
	input wire logic        headphone_common_output_differential_o,
	input wire logic        headphone_common_output_constant_vcm_o,
	input wire logic        headphone_common_output_single_ended_o,
	input wire logic        short_protect_en_o,
	input wire logic        short_current_limit_o,
	input wire logic        driver_power_down_o,
	input wire logic [1:0]  common_mode_sel_o,
	input wire logic        volume_step_o,
	input wire logic [4:0]  right_noise_debounce_o,
	input wire logic        right_signal_below_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// ****************************************
	// write: address phase, then data phase
	// ****************************************
	sequence s_addr(logic [7:0] idx);
		hsel_i && hready_i && htrans_i[1] && hwrite_i &&
			haddr_i[9:2] == idx;
	endsequence
	sequence s_write(logic [7:0] idx);
		s_addr(idx) ##1 hready_i;
	endsequence

	a_dac_write: assert property (
		s_write(IDX_DAC_POWER_HP) |=>
			dac_power_left_o == $past(hwdata_i[7]))
		else $error("dac power bit not taken from write");
	a_vcm_write: assert property (
		s_write(IDX_OUT_BYPASS) |=>
			common_mode_sel_o == $past(hwdata_i[7:6]))
		else $error("common mode field not taken from write");
	a_noise_code_write: assert property (
		s_write(IDX_RIGHT_DEBOUNCE) |=>
			right_noise_debounce_o == $past(hwdata_i[7:3]))
		else $error("noise debounce code not taken from write");
	a_headphone_common_output_one_hot: assert property (
		$onehot0({headphone_common_output_differential_o, headphone_common_output_constant_vcm_o,
			headphone_common_output_single_ended_o}))
		else $error("headphone common modes overlap");
	a_limit_needs_en: assert property (
		short_current_limit_o |-> short_protect_en_o)
		else $error("current limit without protection");
	a_power_down_cause: assert property (
		$rose(driver_power_down_o) |-> $past(short_detected_i) &&
			short_protect_en_o && !short_current_limit_o)
		else $error("driver powered down without short");
	a_step_on_tick: assert property (
		volume_step_o |-> $past(sample_tick_i))
		else $error("volume step without sample tick");
	a_below_cause: assert property (
		$rose(right_signal_below_o) |-> $past(below_noise_right_i)
			|| $past(below_noise_right_i, 2))
		else $error("signal detect flag rose with signal present");
endmodule : agc_regs_monitor

bind codec_agc_status_output_ctrl_regs agc_regs_monitor i_agc_regs_monitor (
	.clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hwdata_i, .hready_i, .short_detected_i, .sample_tick_i,
	.below_noise_right_i, .dac_power_left_o, .headphone_common_output_differential_o,
	.headphone_common_output_constant_vcm_o, .headphone_common_output_single_ended_o, .short_protect_en_o,
	.short_current_limit_o, .driver_power_down_o, .common_mode_sel_o,
	.volume_step_o, .right_noise_debounce_o, .right_signal_below_o
);

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
	import codec_regs_pkg::*;
;
	logic        clk_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o;
	logic [1:0]  htrans_i, common_mode_sel_o;
	logic [2:0]  hsize_i, right_signal_debounce_o;
	logic        hresp_o, irq_o, volume_step_o, right_signal_below_o;
	logic [7:0]  pga_applied_left_i, pga_programmed_left_i;
	logic [7:0]  pga_applied_right_i, pga_programmed_right_i;
	logic [7:0]  agc_gain_left_i, agc_max_left_i;
	logic [7:0]  agc_gain_right_i, agc_max_right_i;
	logic        adc_powered_left_i, adc_powered_right_i;
	logic        below_noise_left_i, below_noise_right_i;
	logic        double_rate_audio_i, short_detected_i, sample_tick_i;
	logic        dac_power_left_o, dac_power_right_o;
	logic        headphone_common_output_differential_o, headphone_common_output_constant_vcm_o;
	logic        headphone_common_output_single_ended_o, short_protect_en_o;
	logic        short_current_limit_o, driver_power_down_o;
	logic        left_line2_positive_o, left_line2_negative_o;
	logic        right_line2_positive_o, right_line2_negative_o;
	logic [4:0]  right_noise_debounce_o;
	logic [7:0]  rv;
	int          fail_count, check_count, step_count;
	wire  [7:0]  hp_out = {dac_power_left_o, dac_power_right_o, 3'h0,
		headphone_common_output_differential_o, headphone_common_output_constant_vcm_o, headphone_common_output_single_ended_o};
	wire  [7:0]  sc_out = {5'h0, short_protect_en_o, short_current_limit_o,
		driver_power_down_o};
	wire  [7:0]  by_out = {common_mode_sel_o, left_line2_negative_o,
		left_line2_positive_o, right_line2_negative_o,
		right_line2_positive_o, 2'h0};
	wire  [7:0]  db_out = {right_noise_debounce_o, right_signal_debounce_o};

	codec_agc_status_output_ctrl_regs #(
		.DEBOUNCE_UNIT_CYCLES(4),
		.GAIN_W(8)
	) i_codec_agc_status_output_ctrl_regs (
		.clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o,
		.hresp_o, .hrdata_o, .pga_applied_left_i, .pga_programmed_left_i,
		.pga_applied_right_i, .pga_programmed_right_i, .adc_powered_left_i,
		.adc_powered_right_i, .below_noise_left_i, .below_noise_right_i,
		.agc_gain_left_i, .agc_max_left_i, .agc_gain_right_i,
		.agc_max_right_i, .double_rate_audio_i, .short_detected_i,
		.sample_tick_i, .dac_power_left_o, .dac_power_right_o,
		.headphone_common_output_differential_o, .headphone_common_output_constant_vcm_o, .headphone_common_output_single_ended_o,
		.short_protect_en_o, .short_current_limit_o, .driver_power_down_o,
		.common_mode_sel_o, .left_line2_positive_o, .left_line2_negative_o,
		.right_line2_positive_o, .right_line2_negative_o, .volume_step_o,
		.right_noise_debounce_o, .right_signal_debounce_o,
		.right_signal_below_o, .irq_o
	);

	// ****************************************
	// clock, counters and shared tasks
	// ****************************************
	initial
	begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (volume_step_o === 1'h1)
			step_count++;

	task automatic stop_test();
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	// one single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] wd);
		hsel_i   <= 1'h1;
		haddr_i  <= {22'h0, idx, 2'h0};
		htrans_i <= AHB_NONSEQ;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'h1);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, wd};
		do @(posedge clk_i); while (hreadyout_o !== 1'h1);
		rv = hrdata_o[7:0];
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		bus(1'h1, idx, wd);
		cyc(1);
	endtask : wr

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'h0, idx, 8'h00);
		check(rv, exp);
	endtask : rd_chk

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		for (int i = 'h23; i <= 'h2A; i++)
			rd_chk(i[7:0], 8'h00);
		rd_chk(8'h31, 8'h00);
		check({7'h0, hresp_o}, 8'h00);
	endtask : t_reset

	task automatic t_rw();
		logic [7:0] idx [6];
		logic [7:0] exp [6];
		logic [7:0] wd  [6];
		idx = '{IDX_RIGHT_DEBOUNCE, IDX_ADC_FLAGS, IDX_DAC_POWER_HP,
			IDX_HP_SHORT, IDX_RESERVED, IDX_OUT_BYPASS};
		exp = '{8'hFF, 8'h00, 8'hF0, 8'h06, 8'h00, 8'hFF};
		wd  = '{8'hFF, 8'hFF, 8'hF0, 8'h06, 8'h00, 8'hFF};
		for (int i = 0; i < 6; i++)
		begin
			// reserved bits and the reserved register stay unwritten
			if (idx[i] != IDX_RESERVED)
				wr(idx[i], wd[i]);
			rd_chk(idx[i], exp[i]);
		end
		check(db_out, 8'hFF);
		check(hp_out, 8'hC0);
		check(sc_out, 8'h04);
		check(by_out, 8'hFC);
	endtask : t_rw

	task automatic t_codes();
		logic [1:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			wr(IDX_DAC_POWER_HP, {2'h2, c, 4'h0});
			check(hp_out, {5'h10, c == 2'h0, c == 2'h1, c == 2'h2});
			wr(IDX_HP_SHORT, {5'h0, c, 1'h0});
			check(sc_out, {5'h0, c[1], c == 2'h2, 1'h0});
			wr(IDX_OUT_BYPASS, {c, c, c, c});
			check(by_out, {c, c[1], c[0], c[1], c[0], 2'h0});
		end
	endtask : t_codes

	task automatic t_flags();
		logic [7:0] p;
		wr(IDX_RIGHT_DEBOUNCE, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			p = (i < 8) ? (8'h80 >> i) : {8{i[0]}};
			pga_applied_left_i  <= {7'h0, p[7]};
			adc_powered_left_i  <= p[6];
			below_noise_left_i  <= p[5];
			agc_gain_left_i     <= {8{p[4]}};
			pga_applied_right_i <= {7'h0, p[3]};
			adc_powered_right_i <= p[2];
			below_noise_right_i <= p[1];
			agc_gain_right_i    <= {8{p[0]}};
			cyc(4);
			rd_chk(IDX_ADC_FLAGS, p);
			rd_chk(IDX_ADC_FLAGS, p);
		end
	endtask : t_flags

	task automatic edge_run(input logic up, input int lo, input int hi);
		below_noise_right_i <= up;
		cyc(lo);
		check({7'h0, right_signal_below_o}, {7'h0, !up});
		cyc(hi - lo);
		check({7'h0, right_signal_below_o}, {7'h0, up});
	endtask : edge_run

	task automatic t_debounce();
		// leave the detector settled above the noise threshold first
		below_noise_right_i <= 1'h0;
		cyc(4);
		wr(IDX_RIGHT_DEBOUNCE, 8'h1B);
		edge_run(1'h1, 27, 38);
		edge_run(1'h0, 10, 22);
		double_rate_audio_i <= 1'h1;
		edge_run(1'h1, 10, 22);
		edge_run(1'h0, 1, 15);
		double_rate_audio_i <= 1'h0;
		wr(IDX_RIGHT_DEBOUNCE, 8'h43);
		edge_run(1'h1, 500, 522);
		edge_run(1'h0, 10, 22);
	endtask : t_debounce

	task automatic pulse_short();
		short_detected_i <= 1'h1;
		cyc(1);
		short_detected_i <= 1'h0;
		cyc(2);
	endtask : pulse_short

	task automatic t_irq();
		// both loops out of saturation so the next rise is an event
		agc_gain_left_i  <= 8'h00;
		agc_gain_right_i <= 8'h00;
		cyc(3);
		bus(1'h0, IDX_IRQ_STATUS, 8'h00);
		wr(IDX_IRQ_MASK, 8'h00);
		agc_gain_left_i <= 8'hFF;
		cyc(3);
		check({7'h0, irq_o}, 8'h00);
		rd_chk(IDX_IRQ_STATUS, 8'h02);
		rd_chk(IDX_IRQ_STATUS, 8'h00);
		wr(IDX_IRQ_MASK, 8'h0F);
		agc_gain_right_i <= 8'hFF;
		cyc(3);
		check({7'h0, irq_o}, 8'h01);
		rd_chk(IDX_IRQ_STATUS, 8'h04);
		cyc(2);
		check({7'h0, irq_o}, 8'h00);
		wr(IDX_HP_SHORT, 8'h06);
		pulse_short();
		check(sc_out, 8'h05);
		rd_chk(IDX_IRQ_STATUS, 8'h08);
		wr(IDX_HP_SHORT, 8'h04);
		cyc(2);
		check(sc_out, 8'h06);
		pulse_short();
		check(sc_out, 8'h06);
		rd_chk(IDX_IRQ_STATUS, 8'h08);
		wr(IDX_HP_SHORT, 8'h00);
		pulse_short();
		rd_chk(IDX_IRQ_STATUS, 8'h00);
	endtask : t_irq

	task automatic t_step();
		logic [7:0] exp [4];
		exp = '{8'h08, 8'h04, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			wr(IDX_OUT_BYPASS, {6'h0, i[1:0]});
			step_count = 0;
			repeat (8)
			begin
				sample_tick_i <= 1'h1;
				cyc(1);
				sample_tick_i <= 1'h0;
				cyc(3);
			end
			cyc(2);
			check(step_count[7:0], exp[i]);
		end
	endtask : t_step

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		fail_count = 0;
		check_count = 0;
		step_count = 0;
		reset_n_i = 1'h0;
		{hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
		hsize_i = 3'h2;
		{pga_applied_left_i, pga_applied_right_i} = '0;
		pga_programmed_left_i = 8'h01;
		pga_programmed_right_i = 8'h01;
		{agc_gain_left_i, agc_gain_right_i} = '0;
		agc_max_left_i = 8'hFF;
		agc_max_right_i = 8'hFF;
		{adc_powered_left_i, adc_powered_right_i} = '0;
		{below_noise_left_i, below_noise_right_i} = '0;
		{double_rate_audio_i, short_detected_i, sample_tick_i} = '0;
		cyc(5);
		reset_n_i <= 1'h1;
		cyc(1);
		t_reset();
		t_rw();
		t_codes();
		t_flags();
		t_debounce();
		t_irq();
		t_step();
		stop_test();
	end

	initial
	begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule : tb

`default_nettype wire
